// File: rtl/pioblk_pkg.sv
// Constants and types shared by the programmable I/O port block
package pioblk_pkg;
  // Port widths
  localparam int PIOBLK_WIDE_W = 8;
  localparam int PIOBLK_D_W = 3;
  localparam int PIOBLK_IMC_N = 20;
  localparam int PIOBLK_IMC_C_N = 4;
  // Reset values of configuration registers
  localparam logic [7:0] PIOBLK_CFG_RST = 8'h00;
  localparam logic [2:0] PIOBLK_CFG_D_RST = 3'h0;
  // Peripheral I/O enable position in memory_map_config
  localparam int PIOBLK_VM_PIO_BIT = 7;
  // Output mux source encodings
  typedef enum logic [1:0] {
    PIOBLK_SRC_DOUT = 2'h0,
    PIOBLK_SRC_ADDR = 2'h1,
    PIOBLK_SRC_CELL = 2'h2,
    PIOBLK_SRC_ECS = 2'h3
  } pioblk_src_t;
  // Input cell mode encodings
  typedef enum logic [1:0] {
    PIOBLK_IMC_PASS = 2'h0,
    PIOBLK_IMC_LATCH = 2'h1,
    PIOBLK_IMC_REG = 2'h2
  } pioblk_imc_mode_t;
  // Read-back select encodings
  typedef enum logic [2:0] {
    PIOBLK_RB_DOUT = 3'h0,
    PIOBLK_RB_CELL = 3'h1,
    PIOBLK_RB_DIR = 3'h2,
    PIOBLK_RB_CTRL = 3'h3,
    PIOBLK_RB_PIN = 3'h4,
    PIOBLK_RB_IMC = 3'h5
  } pioblk_rb_t;
  // Port select for read-back and writes
  localparam logic [1:0] PIOBLK_PORT_A = 2'h0;
  localparam logic [1:0] PIOBLK_PORT_B = 2'h1;
  localparam logic [1:0] PIOBLK_PORT_C = 2'h2;
  localparam logic [1:0] PIOBLK_PORT_D = 2'h3;
endpackage

// File: rtl/pioblk_input_cell.sv
// One input cell: pass-through, transparent latch or edge register
`timescale 1ns/1ps
module pioblk_input_cell
  import pioblk_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration
  input wire logic [1:0] mode,
  input wire logic use_strobe,
  // Enables
  input wire logic term_en,
  input wire logic addr_strobe,
  // Data
  input wire logic pin_in,
  output logic cell_out
);
  logic gate;
  logic gate_q;
  logic hold_q;

  // Latch enable or register clock chosen from term or address strobe
  assign gate = use_strobe ? addr_strobe : term_en;

  // Edge history for register mode
  always_ff @(posedge clk) begin
    if (reset) begin
      gate_q <= 1'b0;
    end else begin
      gate_q <= gate;
    end
  end

  // Stored value; latch follows while open, register samples on rising edge
  always_ff @(posedge clk) begin
    if (reset) begin
      hold_q <= 1'b0;
    end else if (mode == PIOBLK_IMC_LATCH && gate) begin
      hold_q <= pin_in;
    end else if (mode == PIOBLK_IMC_REG && gate && !gate_q) begin
      hold_q <= pin_in;
    end
  end

  // Pass-through gives the pin directly; latch is transparent while open
  always_comb begin
    if (mode == PIOBLK_IMC_PASS) begin
      cell_out = pin_in;
    end else if (mode == PIOBLK_IMC_LATCH && gate) begin
      cell_out = pin_in;
    end else begin
      cell_out = hold_q;
    end
  end
endmodule

// File: rtl/pioblk_top.sv
// Programmable I/O ports A-D: output mux, driver enable, input cells, read-back
`timescale 1ns/1ps
module pioblk_top
  import pioblk_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // MCU write port for run-time registers
  input wire logic wr_en,
  input wire logic [1:0] wr_port,
  input wire logic [2:0] wr_sel,
  input wire logic [7:0] wr_data,
  // MCU read-back port
  input wire logic rd_en,
  input wire logic [1:0] rd_port,
  input wire logic [2:0] rd_sel,
  output logic [7:0] port_readback_buffer,
  output logic port_readback_oe,
  // MCU bus signals
  input wire logic addr_strobe,
  input wire logic [7:0] mcu_addr,
  input wire logic [7:0] mcu_wdata,
  output logic [7:0] mcu_rdata,
  // Peripheral I/O controls
  input wire logic [7:0] memory_map_config,
  input wire logic periph_select_0,
  input wire logic periph_select_1,
  input wire logic program_fetch_strobe,
  // Fixed configuration: pin as logic output, enable term defined, internal node
  input wire logic [26:0] cfg_cell_out,
  input wire logic [26:0] cfg_oe_defined,
  input wire logic [26:0] cfg_internal_node,
  input wire logic [2:0] cfg_ecs_pin,
  // Fixed input cell configuration
  input wire logic [39:0] cfg_imc_mode,
  input wire logic [4:0] cfg_imc_use_strobe,
  // Logic array terms and outputs
  input wire logic [26:0] oe_term,
  input wire logic [26:0] cell_data,
  input wire logic [2:0] ext_chip_selects,
  input wire logic [4:0] imc_term,
  // Pins
  input wire logic [26:0] pin_in,
  output logic [26:0] pin_out,
  output logic [26:0] pin_oe,
  // Feedback to the logic array
  output logic [19:0] input_cell,
  output logic [26:0] output_cell
);
  // Run-time registers, bit order D,C,B,A from high to low
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  logic [26:0] dir_q;
  logic [26:0] dout_q;
  logic [7:0] addr_q;
  logic [26:0] ctrl_all;
  logic [26:0] mux_out;
  logic [26:0] oe_comb;
  logic [26:0] pin_out_d;
  logic [26:0] pin_oe_d;
  logic [19:0] imc_out;
  logic [19:0] imc_pins;
  logic [7:0] rb_d;
  logic periph_mode;
  logic periph_on;
  logic [26:0] ecs_sel;
  logic [26:0] ecs_val;

  // Pin vectors pack the ports from low to high bits:
  // port A on 7:0, port B on 15:8, port C on 23:16 and port D on 26:24.
  // Run-time registers use the same packing, so one index names one pin
  // in every vector; only the control registers are split, as C and D have none.
  // All pin and bus outputs are registered: a direct input such as cell_data shows one
  // clock later (two through the run-time registers), which costs latency but keeps the pins glitch free.

  // Control registers exist for A and B only; C and D read as MCU I/O
  assign ctrl_all = {11'h000, ctrl_b_q, ctrl_a_q};

  // Peripheral mode is bit 7 of memory_map_config; the buffer drives only with both selects active
  assign periph_mode = memory_map_config[PIOBLK_VM_PIO_BIT];
  assign periph_on = periph_mode && periph_select_0 && periph_select_1;

  // Data-out register; fixed pin modes come only from the cfg ports, never from writes
  always_ff @(posedge clk) begin
    if (reset) begin
      dout_q <= {PIOBLK_CFG_D_RST, PIOBLK_CFG_RST, PIOBLK_CFG_RST, PIOBLK_CFG_RST};
    end else if (wr_en && wr_sel == PIOBLK_RB_DOUT) begin
      unique case (wr_port)
        PIOBLK_PORT_A: dout_q[7:0] <= wr_data;
        PIOBLK_PORT_B: dout_q[15:8] <= wr_data;
        PIOBLK_PORT_C: dout_q[23:16] <= wr_data;
        PIOBLK_PORT_D: dout_q[26:24] <= wr_data[2:0];
      endcase
    end
  end

  // Direction register: a 1 makes the pin an output, all bits reset to 0, so pins start as inputs unless set as logic outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      dir_q <= {PIOBLK_CFG_D_RST, PIOBLK_CFG_RST, PIOBLK_CFG_RST, PIOBLK_CFG_RST};
    end else if (wr_en && wr_sel == PIOBLK_RB_DIR) begin
      unique case (wr_port)
        PIOBLK_PORT_A: dir_q[7:0] <= wr_data;
        PIOBLK_PORT_B: dir_q[15:8] <= wr_data;
        PIOBLK_PORT_C: dir_q[23:16] <= wr_data;
        // Port D has three pins; the upper write bits are dropped
        PIOBLK_PORT_D: dir_q[26:24] <= wr_data[2:0];
      endcase
    end
  end

  // Control registers; a write aimed at C or D is dropped as there is no register
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_a_q <= PIOBLK_CFG_RST;
      ctrl_b_q <= PIOBLK_CFG_RST;
    end else if (wr_en && wr_sel == PIOBLK_RB_CTRL) begin
      if (wr_port == PIOBLK_PORT_A) begin
        ctrl_a_q <= wr_data;
      end else if (wr_port == PIOBLK_PORT_B) begin
        ctrl_b_q <= wr_data;
      end
    end
  end

  // Address latch follows the bus while the address strobe is high
  always_ff @(posedge clk) begin
    if (reset) begin
      addr_q <= 8'h00;
    end else if (addr_strobe) begin
      addr_q <= mcu_addr;
    end
  end

  // Chip selects reach port D only; pad them to the pin positions
  assign ecs_sel = {cfg_ecs_pin, 24'h000000};
  assign ecs_val = {ext_chip_selects, 24'h000000};

  // Output mux per pin; a cell kept as an internal node leaves its pin to the other sources
  always_comb begin
    for (int i = 0; i < 27; i++) begin
      if (cfg_cell_out[i] && !cfg_internal_node[i]) begin
        mux_out[i] = cell_data[i];
      end else if (ecs_sel[i]) begin
        mux_out[i] = ecs_val[i];
      end else if (ctrl_all[i]) begin
        // Pins 7:0 of ports A and B carry address bits 7:0 by position
        mux_out[i] = addr_q[i % 8];
      end else begin
        mux_out[i] = dout_q[i];
      end
    end
  end

  // Driver enable per pin; an undefined enable term is taken as active on a logic output pin, a defined term is ORed with dir_q, else dir_q decides
  always_comb begin
    for (int i = 0; i < 27; i++) begin
      if (cfg_cell_out[i] && !cfg_internal_node[i] && !cfg_oe_defined[i]) begin
        oe_comb[i] = 1'b1;
      end else if (cfg_oe_defined[i]) begin
        oe_comb[i] = oe_term[i] | dir_q[i];
      end else begin
        oe_comb[i] = dir_q[i];
      end
    end
  end

  // Peripheral mode takes all of port A as the MCU data buffer. The buffer drives
  // only while both selects are high; the fetch strobe also blocks it, so a select
  // equation that forgot the strobe still cannot drive during program fetches.
  // Port A pin modes set by the cfg ports are overridden while the mode is on.
  always_comb begin
    pin_out_d = mux_out;
    pin_oe_d = oe_comb;
    if (periph_mode) begin
      pin_out_d[7:0] = mcu_wdata;
      pin_oe_d[7:0] = {8{periph_on && !program_fetch_strobe}};
    end
  end

  // Registered pin data; one cycle behind the mux, as every output is a flip-flop
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_out <= 27'h0000000;
    end else begin
      pin_out <= pin_out_d;
    end
  end

  // Registered driver enable; reset leaves every pin released
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_oe <= 27'h0000000;
    end else begin
      pin_oe <= pin_oe_d;
    end
  end

  // Cell feedback always reaches the array, even as internal node
  always_ff @(posedge clk) begin
    if (reset) begin
      output_cell <= 27'h0000000;
    end else begin
      output_cell <= cell_data;
    end
  end

  // Twenty input cells on A, B and C2,C3,C4,C7. Cells go in groups of four that
  // share one gate term and one strobe choice, so the groups are nibbles of A
  // and B plus the four port C cells. In register mode a cell samples on the
  // clock after its gate rises, so a gate must stay high for a full cycle.
  assign imc_pins = {pin_in[23], pin_in[20:18], pin_in[15:0]};

  for (genvar g = 0; g < PIOBLK_IMC_N; g++) begin : g_imc
    pioblk_input_cell u_cell (
      .clk(clk),
      .reset(reset),
      .mode(cfg_imc_mode[2 * g +: 2]),
      .use_strobe(cfg_imc_use_strobe[g / 4]),
      .term_en(imc_term[g / 4]),
      .addr_strobe(addr_strobe),
      .pin_in(imc_pins[g]),
      .cell_out(imc_out[g])
    );
  end

  // Input cells feed the array bus
  always_ff @(posedge clk) begin
    if (reset) begin
      input_cell <= 20'h00000;
    end else begin
      input_cell <= imc_out;
    end
  end

  // Read-back picks exactly one source. The buffer cannot short two sources as
  // the select is a single code; codes without a source read as zero. Port D has
  // three pins, so its upper bits read as zero, and only A and B have control.
  always_comb begin
    rb_d = 8'h00;
    unique case (rd_sel)
      PIOBLK_RB_DOUT: begin
        unique case (rd_port)
          PIOBLK_PORT_A: rb_d = dout_q[7:0];
          PIOBLK_PORT_B: rb_d = dout_q[15:8];
          PIOBLK_PORT_C: rb_d = dout_q[23:16];
          PIOBLK_PORT_D: rb_d = {5'h00, dout_q[26:24]};
        endcase
      end
      PIOBLK_RB_CELL: begin
        unique case (rd_port)
          PIOBLK_PORT_A: rb_d = cell_data[7:0];
          PIOBLK_PORT_B: rb_d = cell_data[15:8];
          PIOBLK_PORT_C: rb_d = cell_data[23:16];
          PIOBLK_PORT_D: rb_d = {5'h00, cell_data[26:24]};
        endcase
      end
      PIOBLK_RB_DIR: begin
        unique case (rd_port)
          PIOBLK_PORT_A: rb_d = dir_q[7:0];
          PIOBLK_PORT_B: rb_d = dir_q[15:8];
          PIOBLK_PORT_C: rb_d = dir_q[23:16];
          PIOBLK_PORT_D: rb_d = {5'h00, dir_q[26:24]};
        endcase
      end
      PIOBLK_RB_CTRL: begin
        unique case (rd_port)
          PIOBLK_PORT_A: rb_d = ctrl_a_q;
          PIOBLK_PORT_B: rb_d = ctrl_b_q;
          default: rb_d = 8'h00;
        endcase
      end
      PIOBLK_RB_PIN: begin
        // Data-in path: the pin level itself, whoever drives it
        unique case (rd_port)
          PIOBLK_PORT_A: rb_d = pin_in[7:0];
          PIOBLK_PORT_B: rb_d = pin_in[15:8];
          PIOBLK_PORT_C: rb_d = pin_in[23:16];
          PIOBLK_PORT_D: rb_d = {5'h00, pin_in[26:24]};
        endcase
      end
      PIOBLK_RB_IMC: begin
        // Port C cells land on their pin bit positions
        unique case (rd_port)
          PIOBLK_PORT_A: rb_d = imc_out[7:0];
          PIOBLK_PORT_B: rb_d = imc_out[15:8];
          PIOBLK_PORT_C: rb_d = {imc_out[19], 2'h0, imc_out[18:16], 2'h0};
          default: rb_d = 8'h00;
        endcase
      end
      default: rb_d = 8'h00;
    endcase
  end

  // Registered read-back; the enable marks the one cycle the buffer drives the bus
  always_ff @(posedge clk) begin
    if (reset) begin
      port_readback_buffer <= 8'h00;
      port_readback_oe <= 1'b0;
    end else begin
      port_readback_buffer <= rb_d;
      port_readback_oe <= rd_en;
    end
  end

  // Port A pins back to the MCU data bus, the inbound half of peripheral mode
  always_ff @(posedge clk) begin
    if (reset) begin
      mcu_rdata <= 8'h00;
    end else begin
      mcu_rdata <= pin_in[7:0];
    end
  end
endmodule

// File: bench/pioblk_pin_model.sv
// Pin-side model: external drivers and floating lines seen by the port pins
`timescale 1ns/1ps
module pioblk_pin_model (
  // Clock
  input wire logic clk,
  // Block side
  input wire logic [26:0] pin_out,
  input wire logic [26:0] pin_oe,
  output logic [26:0] pin_in,
  // Bench side external drivers
  input wire logic [26:0] ext_val,
  input wire logic [26:0] ext_en
);
  logic [26:0] float_q = 27'h0;
  // Undriven lines toggle so a stale value never reads as a match
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  // Block driver wins; otherwise external driver, else floating pattern
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & float_q);
endmodule

// File: bench/pioblk_chk.sv
// Concurrent checks on the port block pins and feedback outputs
`timescale 1ns/1ps
module pioblk_chk
  import pioblk_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Inputs watched
  input wire logic rd_en,
  input wire logic [7:0] memory_map_config,
  input wire logic periph_select_0,
  input wire logic periph_select_1,
  input wire logic program_fetch_strobe,
  input wire logic [7:0] mcu_wdata,
  input wire logic [26:0] oe_term,
  input wire logic [26:0] cfg_cell_out,
  input wire logic [26:0] cfg_oe_defined,
  input wire logic [26:0] cell_data,
  input wire logic [39:0] cfg_imc_mode,
  input wire logic [4:0] cfg_imc_use_strobe,
  input wire logic [4:0] imc_term,
  input wire logic [26:0] pin_in,
  // Outputs watched
  input wire logic port_readback_oe,
  input wire logic [26:0] pin_out,
  input wire logic [26:0] pin_oe,
  input wire logic [26:0] output_cell,
  input wire logic [19:0] input_cell
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Pin and buffer enables and cell feedback; all but the read-back check skip the first edge after reset as outputs are still cleared
  a_readback_one_cycle: assert property (1'b1 |=> port_readback_oe == $past(rd_en))
    else $error("readback enable does not follow read request");
  a_term_enables_pin: assert property (!$past(reset) && cfg_oe_defined[8] && oe_term[8] |=> pin_oe[8])
    else $error("enable term did not drive pin");
  a_logic_out_on: assert property (!$past(reset) && cfg_cell_out[18] && !cfg_oe_defined[18] |=> pin_oe[18])
    else $error("logic output without enable term not driven");
  a_cell_feedback: assert property (!$past(reset) |=> output_cell == $past(cell_data))
    else $error("cell feedback lost");
  // Input cells: pass-through follows the pin, closed latch holds
  a_pass_cell: assert property (!$past(reset) && cfg_imc_mode[9:8] == PIOBLK_IMC_PASS
    |=> input_cell[4] == $past(pin_in[4]))
    else $error("pass-through cell does not follow pin");
  a_latch_closed: assert property (!$past(reset) && cfg_imc_mode[1:0] == PIOBLK_IMC_LATCH
    && !cfg_imc_use_strobe[0] && !imc_term[0] |=> $stable(input_cell[0]))
    else $error("closed latch changed");
  // Peripheral mode on port A
  a_periph_drive: assert property (memory_map_config[7] && periph_select_0 && periph_select_1
    && !program_fetch_strobe |=> pin_oe[7:0] == 8'hFF && pin_out[7:0] == $past(mcu_wdata))
    else $error("peripheral buffer not driving");
  a_periph_off: assert property (memory_map_config[7] && !(periph_select_0 && periph_select_1)
    |=> pin_oe[7:0] == 8'h00)
    else $error("peripheral buffer not off");
endmodule
bind pioblk_top pioblk_chk pioblk_chk_inst (.clk, .reset, .rd_en, .memory_map_config, .periph_select_0,
  .periph_select_1, .program_fetch_strobe, .mcu_wdata, .oe_term, .cfg_cell_out, .cfg_oe_defined, .cell_data,
  .cfg_imc_mode, .cfg_imc_use_strobe, .imc_term, .pin_in, .port_readback_oe, .pin_out, .pin_oe, .output_cell,
  .input_cell);

// File: bench/pioblk_top_tb_top.sv
// Self-checking testbench for the programmable I/O port block
`timescale 1ns/1ps
module pioblk_top_tb_top;
  import pioblk_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic wr_en, rd_en, addr_strobe, periph_select_0, periph_select_1, program_fetch_strobe, port_readback_oe;
  logic [1:0] wr_port, rd_port;
  logic [2:0] wr_sel, rd_sel, cfg_ecs_pin, ext_chip_selects;
  logic [7:0] wr_data, mcu_addr, mcu_wdata, memory_map_config, port_readback_buffer, mcu_rdata;
  logic [26:0] cfg_cell_out, cfg_oe_defined, cfg_internal_node, oe_term, cell_data, pin_in, pin_out, pin_oe;
  logic [26:0] output_cell, ext_val, ext_en;
  logic [39:0] cfg_imc_mode;
  logic [4:0] cfg_imc_use_strobe, imc_term;
  logic [19:0] input_cell;
  int err_total = 0;
  int compares = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  pioblk_top pioblk_top_inst (.clk, .reset, .wr_en, .wr_port, .wr_sel, .wr_data, .rd_en, .rd_port, .rd_sel,
    .port_readback_buffer, .port_readback_oe, .addr_strobe, .mcu_addr, .mcu_wdata, .mcu_rdata, .memory_map_config,
    .periph_select_0, .periph_select_1, .program_fetch_strobe, .cfg_cell_out, .cfg_oe_defined, .cfg_internal_node,
    .cfg_ecs_pin, .cfg_imc_mode, .cfg_imc_use_strobe, .oe_term, .cell_data, .ext_chip_selects, .imc_term, .pin_in,
    .pin_out, .pin_oe, .input_cell, .output_cell);
  pioblk_pin_model pioblk_pin_model_inst (.clk, .pin_out, .pin_oe, .pin_in, .ext_val, .ext_en);
  // Step to just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input logic [26:0] got, input logic [26:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Write, then one idle cycle so the pins have settled on return
  task automatic wr(input logic [1:0] p, input logic [2:0] s, input logic [7:0] d);
    wr_en = 1'b1;
    wr_port = p;
    wr_sel = s;
    wr_data = d;
    tick(1);
    wr_en = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [1:0] p, input logic [2:0] s, input logic [7:0] exp);
    rd_en = 1'b1;
    rd_port = p;
    rd_sel = s;
    tick(1);
    cmp(27'(port_readback_oe), 27'h1);
    cmp(27'(port_readback_buffer), 27'(exp));
    rd_en = 1'b0;
    tick(1);
  endtask
  task automatic t_reset();
    cmp(pin_oe, 27'h040000);
    rd(PIOBLK_PORT_A, PIOBLK_RB_DIR, 8'h00);
  endtask
  task automatic t_dir();
    wr(PIOBLK_PORT_A, 3'h0, 8'h5A);
    wr(PIOBLK_PORT_A, 3'h2, 8'h0F);
    cmp(27'({pin_oe[7:0], pin_out[7:0]}), 27'h0F5A);
    rd(PIOBLK_PORT_A, PIOBLK_RB_DOUT, 8'h5A);
    ext_val = 27'h0005C3;
    ext_en = 27'h00FFFF;
    rd(PIOBLK_PORT_A, PIOBLK_RB_PIN, 8'hCA);
    wr(PIOBLK_PORT_D, 3'h2, 8'hFF);
    cmp(27'({pin_oe[26:24], pin_out[24]}), 27'hF);
  endtask
  task automatic t_cell();
    oe_term[19] = 1'b1;
    oe_term[8] = 1'b1;
    tick(1);
    cmp(27'({pin_oe[19], pin_out[19], pin_oe[8]}), 27'h7);
    oe_term = 27'h0;
    wr(PIOBLK_PORT_C, 3'h2, 8'h10);
    cmp(27'({pin_oe[20], pin_out[20], output_cell[20], pin_oe[19]}), 27'hA);
    rd(PIOBLK_PORT_C, PIOBLK_RB_CELL, 8'h1C);
  endtask
  task automatic t_addr();
    addr_strobe = 1'b1;
    mcu_addr = 8'hA5;
    wr(PIOBLK_PORT_B, 3'h3, 8'hFF);
    cmp(27'(pin_oe[15:8]), 27'h0);
    wr(PIOBLK_PORT_B, 3'h2, 8'hFF);
    addr_strobe = 1'b0;
    tick(1);
    mcu_addr = 8'h3C;
    tick(2);
    cmp(27'({pin_oe[15:8], pin_out[15:8]}), 27'hFFA5);
    rd(PIOBLK_PORT_B, PIOBLK_RB_CTRL, 8'hFF);
    wr(PIOBLK_PORT_B, 3'h3, 8'h00);
    cmp(27'(pin_out[15:8]), 27'h0);
  endtask
  task automatic t_imc();
    wr(PIOBLK_PORT_B, 3'h2, 8'h00);
    wr(PIOBLK_PORT_A, 3'h2, 8'h00);
    ext_val = 27'h00053C;
    addr_strobe = 1'b1;
    tick(1);
    addr_strobe = 1'b0;
    ext_val = 27'h000A3C;
    imc_term = 5'h05;
    tick(1);
    imc_term = 5'h00;
    ext_val = 27'h000A96;
    tick(2);
    cmp(27'(input_cell[15:0]), 27'h059C);
    rd(PIOBLK_PORT_A, PIOBLK_RB_IMC, 8'h9C);
  endtask
  task automatic t_periph();
    memory_map_config = 8'h80;
    mcu_wdata = 8'hC3;
    tick(1);
    cmp(27'({pin_oe[7:0], pin_out[7:0]}), 27'hFFC3);
    periph_select_1 = 1'b0;
    tick(3);
    cmp(27'({pin_oe[7:0], mcu_rdata}), 27'h0096);
    periph_select_1 = 1'b1;
    program_fetch_strobe = 1'b1;
    tick(1);
    cmp(27'(pin_oe[7:0]), 27'h0);
  endtask
  task automatic results();
    $display("errors %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog well beyond the 48 cycles the run needs
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    {wr_en, rd_en, addr_strobe, program_fetch_strobe} = 4'h0;
    {periph_select_0, periph_select_1} = 2'h3;
    {wr_port, rd_port, wr_sel, rd_sel, wr_data, mcu_addr, mcu_wdata, memory_map_config} = 42'h0;
    {oe_term, ext_val, ext_en, imc_term} = 86'h0;
    cfg_cell_out = 27'h1C0000;
    cfg_oe_defined = 27'h080100;
    cfg_internal_node = 27'h100000;
    cell_data = 27'h1C0000;
    cfg_ecs_pin = 3'h1;
    ext_chip_selects = 3'h1;
    cfg_imc_mode = 40'h0000AA0055;
    cfg_imc_use_strobe = 5'h04;
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    tick(2);
    t_reset();
    t_dir();
    t_cell();
    t_addr();
    t_imc();
    t_periph();
    results();
  end
endmodule
